// ==== verilog/rdn_table.sv ====
// Shared constants and the duplicate-detection table of the redundant frame path.
// ****************************************************************
// Package
// ****************************************************************
package rdn_pkg;
  localparam int CLK_MHZ = 125;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = TICK_NS * CLK_MHZ / 1000;
  localparam int ENTRY_FORGET_US = 400;
  localparam int ENTRY_FORGET_TICKS_DEF = ENTRY_FORGET_US * 1000 / TICK_NS;
  localparam int LIFE_CHECK_US = 2000000;
  localparam int LIFE_CHECK_CYC_DEF = LIFE_CHECK_US * CLK_MHZ;
  localparam int MAC_W = 48;
  localparam int SEQ_W = 16;
  localparam int TOK_W = 16;
  localparam int AGE_W = 12;
  localparam int MC_BIT = 40;
  localparam logic [MAC_W-1:0] SUP_DST_DEF = 48'h01_00_00_00_00_01;
  localparam logic [1:0] BOTH_PORTS = 2'h3;
  localparam logic [1:0] PORT_A_BIT = 2'h1;
  localparam logic [1:0] PORT_B_BIT = 2'h2;
  localparam logic [SEQ_W-1:0] SEQ_ONE = 16'h0001;
  localparam logic [SEQ_W-1:0] SEQ_TWO = 16'h0002;
  typedef enum logic [1:0] {RX_IDLE, RX_WAIT, RX_ACT} rx_st_t;
endpackage

`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Duplicate table
// ****************************************************************
module rdn_table
  import rdn_pkg::*;
#(
  parameter int N  = 16,
  parameter int AW = 12
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic             look,
  input  wire logic             port,
  input  wire logic             tick,
  input  wire logic [MAC_W-1:0] src,
  input  wire logic [SEQ_W-1:0] key,
  input  wire logic [AW-1:0]    forget,
  output logic                  hit_q,
  output logic                  lone_q
);
  logic [N-1:0]         v_q;
  logic [N-1:0]         m;
  logic [N-1:0]         expd;
  logic [N-1:0]         lone;
  logic [MAC_W-1:0]     s_q[N];
  logic [SEQ_W-1:0]     k_q[N];
  logic [1:0]           pm_q[N];
  logic [AW-1:0]        age_q[N];
  logic [$clog2(N)-1:0] ptr_q;
  wire                  any = |m;
  wire  [1:0]           pbit = port ? PORT_B_BIT : PORT_A_BIT;

  // Match on source address plus sequence key; expiry flags old entries.
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_cmp
      assign m[g]    = v_q[g] && s_q[g] == src && k_q[g] == key;
      assign expd[g] = v_q[g] && age_q[g] >= forget;
      assign lone[g] = expd[g] && pm_q[g] != BOTH_PORTS;
    end
  endgenerate

  // Valid bits and result flags; a miss claims the round-robin slot.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      v_q    <= '0;
      ptr_q  <= '0;
      hit_q  <= 1'b0;
      lone_q <= 1'b0;
    end else if (ce) begin
      hit_q  <= look && any;
      lone_q <= |lone;
      v_q    <= v_q & ~expd;
      if (look && !any) begin
        v_q[ptr_q] <= 1'b1;
        ptr_q      <= ptr_q + 1'b1;
      end
    end
  end

  // Entry payload; no reset needed since valid bits guard every read.
  always_ff @(posedge clk) begin
    if (ce) begin
      for (int i = 0; i < N; i++) begin
        if (tick) age_q[i] <= age_q[i] + 1'b1;
        if (look && m[i]) pm_q[i] <= pm_q[i] | pbit;
      end
      if (look && !any) begin
        s_q[ptr_q]   <= src;
        k_q[ptr_q]   <= key;
        pm_q[ptr_q]  <= pbit;
        age_q[ptr_q] <= '0;
      end
    end
  end
endmodule // rdn_table
`default_nettype wire

// ==== verilog/redundant_ethernet_frame_dup.sv ====
// Frame duplication, duplicate discard and ring relay for a two-port redundant node.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - In parallel mode every outgoing frame is sent once on each port.
// - In parallel mode the first received copy is delivered and the later one dropped.
// - Received sequence numbers are checked per port and copies seen on one port only are flagged.
// - Both ports use one shared station address as source.
// - Both ports accept every frame addressed to the station.
// - In ring mode each sent frame becomes two tagged copies carrying destination and sequence.
// - The two ring copies differ only in their sequence number.
// - Each ring copy leaves through a different port.
// - The first ring copy at the destination is delivered untagged and the second discarded.
// - Ring frames are relayed to the other port unless this node injected them or they are unicast to this node.
// - A unicast ring frame for another node is only relayed, never delivered.
// - A unicast ring frame for this node is not relayed further.
// - Table entries are removed after the entry forget time.
// - Supervision frames are sent at the life check interval.
module redundant_ethernet_frame_dup
  import rdn_pkg::*;
#(
  parameter int               TBL_N         = 16,
  parameter int               LIFE_CYC      = LIFE_CHECK_CYC_DEF,
  parameter int               FORGET_TICKS  = ENTRY_FORGET_TICKS_DEF,
  parameter logic [MAC_W-1:0] SUP_DST       = SUP_DST_DEF
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             ce,
  input  wire logic             cfg_ring_mode,
  input  wire logic [MAC_W-1:0] cfg_station_mac,
  input  wire logic             host_tx_valid,
  output logic                  host_tx_ready,
  input  wire logic [MAC_W-1:0] host_tx_dst,
  input  wire logic [TOK_W-1:0] host_tx_tok,
  output logic                  a_tx_valid,
  input  wire logic             a_tx_ready,
  output logic [MAC_W-1:0]      a_tx_dst,
  output logic [MAC_W-1:0]      a_tx_src,
  output logic [SEQ_W-1:0]      a_tx_seq,
  output logic                  a_tx_tagged,
  output logic                  a_tx_sup,
  output logic [TOK_W-1:0]      a_tx_tok,
  output logic                  b_tx_valid,
  input  wire logic             b_tx_ready,
  output logic [MAC_W-1:0]      b_tx_dst,
  output logic [MAC_W-1:0]      b_tx_src,
  output logic [SEQ_W-1:0]      b_tx_seq,
  output logic                  b_tx_tagged,
  output logic                  b_tx_sup,
  output logic [TOK_W-1:0]      b_tx_tok,
  input  wire logic             a_rx_valid,
  output logic                  a_rx_ready,
  input  wire logic [MAC_W-1:0] a_rx_dst,
  input  wire logic [MAC_W-1:0] a_rx_src,
  input  wire logic [SEQ_W-1:0] a_rx_seq,
  input  wire logic [TOK_W-1:0] a_rx_tok,
  input  wire logic             b_rx_valid,
  output logic                  b_rx_ready,
  input  wire logic [MAC_W-1:0] b_rx_dst,
  input  wire logic [MAC_W-1:0] b_rx_src,
  input  wire logic [SEQ_W-1:0] b_rx_seq,
  input  wire logic [TOK_W-1:0] b_rx_tok,
  output logic                  dlv_valid,
  input  wire logic             dlv_ready,
  output logic [MAC_W-1:0]      dlv_dst,
  output logic [MAC_W-1:0]      dlv_src,
  output logic [SEQ_W-1:0]      dlv_seq,
  output logic [TOK_W-1:0]      dlv_tok,
  output logic                  dlv_port,
  output logic [1:0]            seq_err,
  output logic                  lone_copy
);
  // ****************************************************************
  // Reset release and configuration synchronisers
  // ****************************************************************
  logic [1:0]       rst_q;
  logic             ring_s1_q, ring_q;
  logic [MAC_W-1:0] mac_s1_q, mac_q;
  wire              rst_n = rst_q[1];

  // Reset asserts at once and releases after two edges.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) rst_q <= 2'h0;
    else rst_q <= {rst_q[0], 1'b1};
  end

  // Configuration pins are static but asynchronous, so both pass two stages.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ring_s1_q <= 1'b0;
      ring_q    <= 1'b0;
      mac_s1_q  <= '0;
      mac_q     <= '0;
    end else if (ce) begin
      ring_s1_q <= cfg_ring_mode;
      ring_q    <= ring_s1_q;
      mac_s1_q  <= cfg_station_mac;
      mac_q     <= mac_s1_q;
    end
  end

  // Ring copies differ by one in sequence, so the key drops the low bit.
  function automatic logic [SEQ_W-1:0] seq_key(input logic ring, input logic [SEQ_W-1:0] s);
    return ring ? {s[SEQ_W-1:1], 1'b0} : s;
  endfunction

  // ****************************************************************
  // Timers
  // ****************************************************************
  logic [31:0] lc_q;
  logic [15:0] tk_q;
  logic        sup_pend_q;
  wire         lc_wrap = lc_q == 32'(LIFE_CYC - 1);
  wire         tick = tk_q == 16'(TICK_CYC - 1);
  logic        loc_ld;

  // Life check counter raises a supervision request; a new request beats the clear.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lc_q       <= '0;
      tk_q       <= '0;
      sup_pend_q <= 1'b0;
    end else if (ce) begin
      lc_q       <= lc_wrap ? '0 : lc_q + 1'b1;
      tk_q       <= tick ? '0 : tk_q + 1'b1;
      sup_pend_q <= lc_wrap || (sup_pend_q && !loc_ld);
    end
  end

  // ****************************************************************
  // Receive arbitration and decision
  // ****************************************************************
  rx_st_t           st_q;
  logic             sel_q, dup_q;
  logic [MAC_W-1:0] r_dst_q, r_src_q;
  logic [SEQ_W-1:0] r_seq_q;
  logic [TOK_W-1:0] r_tok_q;
  logic             hit_q, lone_q;
  logic [1:0]       tv_q;

  // Port A wins a tie; ready is withheld while frozen so nothing is lost.
  wire              idle = ce && st_q == RX_IDLE;
  wire              take = idle && (a_rx_valid || b_rx_valid);
  wire              pick = !a_rx_valid;
  wire [MAC_W-1:0]  i_src = pick ? b_rx_src : a_rx_src;
  wire [SEQ_W-1:0]  i_seq = pick ? b_rx_seq : a_rx_seq;
  assign a_rx_ready = idle;
  assign b_rx_ready = idle && !a_rx_valid;

  // Decision terms for the frame held in the act state.
  wire own     = r_src_q == mac_q;
  wire mcast   = r_dst_q[MC_BIT];
  wire to_me   = r_dst_q == mac_q;
  wire want_d  = !own && !dup_q && (mcast || to_me);
  wire want_f  = ring_q && !own && !to_me;
  wire fp      = ~sel_q;
  wire act     = ce && st_q == RX_ACT;
  wire go      = act && (!want_d || !dlv_valid) && (!want_f || !tv_q[fp]);
  wire dlv_ld  = go && want_d;
  wire fwd_go  = go && want_f;
  wire fwd_hold = st_q == RX_ACT && want_f;

  rdn_table #(.N(TBL_N), .AW(AGE_W)) u_tbl (
    .clk    (clk),
    .rst_n  (rst_n),
    .ce     (ce),
    .look   (take),
    .port   (pick),
    .tick   (tick),
    .src    (i_src),
    .key    (seq_key(ring_q, i_seq)),
    .forget (AGE_W'(FORGET_TICKS)),
    .hit_q  (hit_q),
    .lone_q (lone_q)
  );

  // Take, look up, then act once there is room at every destination.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q  <= RX_IDLE;
      sel_q <= 1'b0;
      dup_q <= 1'b0;
    end else if (ce) begin
      unique case (st_q)
        RX_IDLE: if (take) begin
          st_q  <= RX_WAIT;
          sel_q <= pick;
        end
        RX_WAIT: begin
          st_q  <= RX_ACT;
          dup_q <= hit_q;
        end
        RX_ACT: if (go) st_q <= RX_IDLE;
      endcase
    end
  end

  // Held fields carry no reset; the state machine guards their use.
  always_ff @(posedge clk) begin
    if (take) begin
      r_dst_q <= pick ? b_rx_dst : a_rx_dst;
      r_src_q <= i_src;
      r_seq_q <= i_seq;
      r_tok_q <= pick ? b_rx_tok : a_rx_tok;
    end
  end

  // ****************************************************************
  // Sequence continuity per port
  // ****************************************************************
  logic [SEQ_W-1:0] lseq_q[2];
  logic [1:0]       lv_q, err_q;
  wire  [SEQ_W-1:0] step = ring_q ? SEQ_TWO : SEQ_ONE;

  // A gap or repeat against the last number seen on that port raises a pulse.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lv_q      <= 2'h0;
      lseq_q    <= '{default: '0};
      err_q     <= 2'h0;
      lone_copy <= 1'b0;
    end else if (ce) begin
      err_q     <= 2'h0;
      lone_copy <= lone_q;
      if (take) begin
        lv_q[pick]   <= 1'b1;
        lseq_q[pick] <= i_seq;
        err_q[pick]  <= lv_q[pick] && i_seq != lseq_q[pick] + step;
      end
    end
  end
  assign seq_err = err_q;

  // ****************************************************************
  // Delivery register
  // ****************************************************************
  // Delivered frames leave with no ring tag indication at all.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dlv_valid <= 1'b0;
      dlv_dst   <= '0;
      dlv_src   <= '0;
      dlv_seq   <= '0;
      dlv_tok   <= '0;
      dlv_port  <= 1'b0;
    end else if (ce) begin
      if (dlv_valid && dlv_ready) dlv_valid <= 1'b0;
      if (dlv_ld) begin
        dlv_valid <= 1'b1;
        dlv_dst   <= r_dst_q;
        dlv_src   <= r_src_q;
        dlv_seq   <= r_seq_q;
        dlv_tok   <= r_tok_q;
        dlv_port  <= sel_q;
      end
    end
  end

  // ****************************************************************
  // Transmit holding registers
  // ****************************************************************
  logic [SEQ_W-1:0] seq_q;
  logic [MAC_W-1:0] tdst_q[2], tsrc_q[2];
  logic [SEQ_W-1:0] tseq_q[2];
  logic [TOK_W-1:0] ttok_q[2];
  logic [1:0]       ttag_q, tsup_q;
  wire  [1:0]       trdy = {b_tx_ready, a_tx_ready};

  // Relay traffic has priority; local frames need both ports free at once.
  assign loc_ld        = ce && tv_q == 2'h0 && !fwd_hold && (sup_pend_q || host_tx_valid);
  assign host_tx_ready = ce && tv_q == 2'h0 && !fwd_hold && !sup_pend_q;

  // Ring sends copy A with seq, copy B with seq plus one.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) seq_q <= '0;
    else if (loc_ld) seq_q <= seq_q + step;
  end

  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_tx
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          tv_q[p]   <= 1'b0;
          tdst_q[p] <= '0;
          tsrc_q[p] <= '0;
          tseq_q[p] <= '0;
          ttok_q[p] <= '0;
          ttag_q[p] <= 1'b0;
          tsup_q[p] <= 1'b0;
        end else if (ce) begin
          if (tv_q[p] && trdy[p]) tv_q[p] <= 1'b0;
          if (fwd_go && fp == 1'(p)) begin
            tv_q[p]   <= 1'b1;
            tdst_q[p] <= r_dst_q;
            tsrc_q[p] <= r_src_q;
            tseq_q[p] <= r_seq_q;
            ttok_q[p] <= r_tok_q;
            ttag_q[p] <= 1'b1;
            tsup_q[p] <= 1'b0;
          end else if (loc_ld) begin
            tv_q[p]   <= 1'b1;
            tdst_q[p] <= sup_pend_q ? SUP_DST : host_tx_dst;
            tsrc_q[p] <= mac_q;
            tseq_q[p] <= seq_q + ((ring_q && p == 1) ? SEQ_ONE : '0);
            ttok_q[p] <= sup_pend_q ? '0 : host_tx_tok;
            ttag_q[p] <= ring_q;
            tsup_q[p] <= sup_pend_q;
          end
        end
      end
    end
  endgenerate

  assign a_tx_valid  = tv_q[0];
  assign a_tx_dst    = tdst_q[0];
  assign a_tx_src    = tsrc_q[0];
  assign a_tx_seq    = tseq_q[0];
  assign a_tx_tagged = ttag_q[0];
  assign a_tx_sup    = tsup_q[0];
  assign a_tx_tok    = ttok_q[0];
  assign b_tx_valid  = tv_q[1];
  assign b_tx_dst    = tdst_q[1];
  assign b_tx_src    = tsrc_q[1];
  assign b_tx_seq    = tseq_q[1];
  assign b_tx_tagged = ttag_q[1];
  assign b_tx_sup    = tsup_q[1];
  assign b_tx_tok    = ttok_q[1];

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_prp_both;
    loc_ld && !ring_q |=> tv_q == BOTH_PORTS && tdst_q[0] == tdst_q[1] && tseq_q[0] == tseq_q[1];
  endproperty
  a_prp_both: assert property (p_prp_both) else $error("parallel copy missing");
  property p_ring_pair;
    loc_ld && ring_q |=> tseq_q[1] == tseq_q[0] + SEQ_ONE && ttag_q == BOTH_PORTS;
  endproperty
  a_ring_pair: assert property (p_ring_pair) else $error("ring copies malformed");
  property p_dup_drop;
    act && dup_q |-> !dlv_ld;
  endproperty
  a_dup_drop: assert property (p_dup_drop) else $error("duplicate delivered");
  property p_stop_me;
    act && to_me |-> !fwd_go;
  endproperty
  a_stop_me: assert property (p_stop_me) else $error("own unicast relayed");
  property p_own;
    act && own |-> !fwd_go && !dlv_ld;
  endproperty
  a_own: assert property (p_own) else $error("own frame relayed");
  property p_mode;
    !ring_q |-> !fwd_go;
  endproperty
  a_mode: assert property (p_mode) else $error("relay in parallel mode");
  property p_src;
    loc_ld |=> tsrc_q[0] == mac_q && tsrc_q[1] == mac_q;
  endproperty
  a_src: assert property (p_src) else $error("source address differs");
  property p_pipe;
    take |=> st_q == RX_WAIT;
  endproperty
  a_pipe: assert property (p_pipe) else $error("lookup stage skipped");
  property p_life;
    ce && lc_wrap |=> sup_pend_q;
  endproperty
  a_life: assert property (p_life) else $error("supervision not requested");

  c_dup: cover property (act && dup_q);
  c_fwd: cover property (fwd_go);
  c_sup: cover property (loc_ld && sup_pend_q);
endmodule // redundant_ethernet_frame_dup
`default_nettype wire

// ==== sim/rdn_peer.sv ====
// Behavioural model of one far-side port: takes transmitted frames and injects received ones.
`timescale 1ns/1ps
`default_nettype none
module rdn_peer
  import rdn_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             slow,
  input  wire logic             tx_valid,
  output var logic              tx_ready,
  input  wire logic [MAC_W-1:0] tx_dst,
  input  wire logic [MAC_W-1:0] tx_src,
  input  wire logic [SEQ_W-1:0] tx_seq,
  input  wire logic             tx_tagged,
  input  wire logic             tx_sup,
  input  wire logic [TOK_W-1:0] tx_tok,
  output var logic              rx_valid,
  input  wire logic             rx_ready,
  output var logic [MAC_W-1:0]  rx_dst,
  output var logic [MAC_W-1:0]  rx_src,
  output var logic [SEQ_W-1:0]  rx_seq,
  output var logic [TOK_W-1:0]  rx_tok,
  output var int                n_got,
  output var logic [MAC_W-1:0]  got_dst,
  output var logic [MAC_W-1:0]  got_src,
  output var logic [SEQ_W-1:0]  got_seq,
  output var logic              got_tag,
  output var logic [TOK_W-1:0]  got_tok
);
  logic stall_q;

  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    {rx_dst, rx_src, rx_seq, rx_tok} = '0;
    n_got = 0;
    stall_q = 1'b0;
  end

  // Slow mode drops ready every other cycle, so the node must hold its copy meanwhile.
  always @(posedge clk) begin
    stall_q <= ~stall_q;
    tx_ready <= slow ? stall_q : 1'b1;
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      n_got <= n_got + 1;
      {got_dst, got_src, got_seq, got_tag, got_tok} <= {tx_dst, tx_src, tx_seq, tx_tagged, tx_tok};
    end
  end

  // Holds the frame until the node takes it or 50 edges pass, then inverts the released lines.
  task automatic inject(input logic [MAC_W-1:0] d, input logic [MAC_W-1:0] s, input logic [SEQ_W-1:0] q,
                        input logic [TOK_W-1:0] t, output bit ok);
    int i;
    ok = 1'b0;
    @(posedge clk);
    #1;
    {rx_dst, rx_src, rx_seq, rx_tok} = {d, s, q, t};
    rx_valid = 1'b1;
    for (i = 0; i < 50 && !ok; i++) begin
      @(posedge clk);
      ok = (rx_ready === 1'b1);
    end
    #1;
    rx_valid = 1'b0;
    {rx_dst, rx_src, rx_seq, rx_tok} = ~{d, s, q, t};
  endtask
endmodule // rdn_peer
`default_nettype wire

// ==== sim/testbench.sv ====
// Self-checking testbench of the redundant frame path against two far-side port models.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rdn_pkg::*;
  localparam logic [MAC_W-1:0] STA = 48'h02_00_00_00_00_10;
  localparam logic [MAC_W-1:0] MC  = 48'h01_00_00_00_00_22;
  localparam logic [MAC_W-1:0] OTH = 48'h02_00_00_00_00_33;
  localparam logic [MAC_W-1:0] SX  = 48'h02_00_00_00_00_A1;
  localparam logic [MAC_W-1:0] SY  = 48'h02_00_00_00_00_A2;
  localparam logic [MAC_W-1:0] SZ  = 48'h02_00_00_00_00_A3;
  logic clk, rst_b, ring, slow_b, hv, hr, dlv_valid, dlv_port, lone;
  logic [MAC_W-1:0] hd, dlv_dst, dlv_src;
  logic [TOK_W-1:0] ht, dlv_tok;
  logic [SEQ_W-1:0] dlv_seq;
  logic [1:0] serr;
  logic av, ar, at, as, bv, br, bt, bs, arv, arr, brv, brr, pa_tag, pb_tag;
  logic [MAC_W-1:0] ad, asr, bd, bsr, ard, ars, brd, brs, pa_dst, pa_src, pb_dst, pb_src;
  logic [SEQ_W-1:0] aq, bq, arq, brq, pa_seq, pb_seq, dl_seq, s1;
  logic [TOK_W-1:0] ak, bk, ark, brk, pa_tok, pb_tok;
  int n_a, n_b, n_dlv, n_ea, n_eb, n_lone, d0, a0, b0, mismatches, num_checks;
  bit dl_port;
  logic ce;
  logic [MAC_W-1:0] dl_dst, dl_src;
  logic [TOK_W-1:0] dl_tok;

  redundant_ethernet_frame_dup #(.LIFE_CYC(4000), .FORGET_TICKS(3), .SUP_DST(SUP_DST_DEF))
    u_redundant_ethernet_frame_dup (
    .clk(clk), .rst_b(rst_b), .ce(ce), .cfg_ring_mode(ring), .cfg_station_mac(STA),
    .host_tx_valid(hv), .host_tx_ready(hr), .host_tx_dst(hd), .host_tx_tok(ht),
    .a_tx_valid(av), .a_tx_ready(ar), .a_tx_dst(ad), .a_tx_src(asr), .a_tx_seq(aq), .a_tx_tagged(at),
    .a_tx_sup(as), .a_tx_tok(ak), .b_tx_valid(bv), .b_tx_ready(br), .b_tx_dst(bd), .b_tx_src(bsr),
    .b_tx_seq(bq), .b_tx_tagged(bt), .b_tx_sup(bs), .b_tx_tok(bk),
    .a_rx_valid(arv), .a_rx_ready(arr), .a_rx_dst(ard), .a_rx_src(ars), .a_rx_seq(arq), .a_rx_tok(ark),
    .b_rx_valid(brv), .b_rx_ready(brr), .b_rx_dst(brd), .b_rx_src(brs), .b_rx_seq(brq), .b_rx_tok(brk),
    .dlv_valid(dlv_valid), .dlv_ready(1'b1), .dlv_dst(dlv_dst), .dlv_src(dlv_src), .dlv_seq(dlv_seq),
    .dlv_tok(dlv_tok), .dlv_port(dlv_port), .seq_err(serr), .lone_copy(lone));
  rdn_peer u_peer_a (.clk(clk), .slow(1'b0), .tx_valid(av), .tx_ready(ar), .tx_dst(ad), .tx_src(asr),
    .tx_seq(aq), .tx_tagged(at), .tx_sup(as), .tx_tok(ak), .rx_valid(arv), .rx_ready(arr), .rx_dst(ard),
    .rx_src(ars), .rx_seq(arq), .rx_tok(ark), .n_got(n_a), .got_dst(pa_dst), .got_src(pa_src),
    .got_seq(pa_seq), .got_tag(pa_tag), .got_tok(pa_tok));
  rdn_peer u_peer_b (.clk(clk), .slow(slow_b), .tx_valid(bv), .tx_ready(br), .tx_dst(bd), .tx_src(bsr),
    .tx_seq(bq), .tx_tagged(bt), .tx_sup(bs), .tx_tok(bk), .rx_valid(brv), .rx_ready(brr), .rx_dst(brd),
    .rx_src(brs), .rx_seq(brq), .rx_tok(brk), .n_got(n_b), .got_dst(pb_dst), .got_src(pb_src),
    .got_seq(pb_seq), .got_tag(pb_tag), .got_tok(pb_tok));

  // ****************************************************************
  // Clock and monitors
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Counts deliveries and pulses; the pulses last one cycle so they are caught at every edge.
  always @(posedge clk) begin
    if (dlv_valid === 1'b1) begin
      n_dlv++;
      dl_seq = dlv_seq;
      dl_port = dlv_port;
      {dl_dst, dl_src, dl_tok} = {dlv_dst, dlv_src, dlv_tok};
    end
    if (serr[0] === 1'b1) n_ea++;
    if (serr[1] === 1'b1) n_eb++;
    if (lone === 1'b1) n_lone++;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string name, input logic [127:0] exp, input logic [127:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic test_done();
    if (mismatches == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic tmo();
    chk("wait", 1, 0);
    test_done();
  endtask

  task automatic snap();
    {d0, a0, b0} = {n_dlv, n_a, n_b};
  endtask

  // Mode pin crosses two flops, so a few idle cycles let it settle.
  task automatic set_mode(input logic m);
    @(posedge clk);
    #1 ring = m;
    repeat (6) @(posedge clk);
  endtask

  task automatic tx_frame(input logic [MAC_W-1:0] d, input logic [TOK_W-1:0] t);
    int i, na, nb;
    bit ok;
    {na, nb} = {n_a, n_b};
    ok = 1'b0;
    @(posedge clk);
    #1 {hd, ht, hv} = {d, t, 1'b1};
    // Ready counts only at an edge, so the request stands until the edge that takes it.
    for (i = 0; i < 100 && !ok; i++) begin
      @(posedge clk);
      ok = (hr === 1'b1);
    end
    if (!ok) tmo();
    #1 hv = 1'b0;
    for (i = 0; i < 100 && !(n_a > na && n_b > nb); i++) @(posedge clk);
    if (i == 100) tmo();
  endtask

  task automatic rx(input bit p, input logic [MAC_W-1:0] d, input logic [MAC_W-1:0] s, input logic [SEQ_W-1:0] q);
    bit ok;
    if (p) u_peer_b.inject(d, s, q, 16'h5A5A, ok);
    else u_peer_a.inject(d, s, q, 16'h5A5A, ok);
    if (!ok) tmo();
    repeat (8) @(posedge clk);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_par_tx();
    set_mode(1'b0);
    tx_frame(OTH, 16'h1111);
    s1 = pa_seq;
    chk("pa_dst", OTH, pa_dst);
    chk("pa_src", STA, pa_src);
    chk("pb_src", STA, pb_src);
    chk("pb_tok", 16'h1111, pb_tok);
    chk("pb_seq", s1, pb_seq);
    chk("pb_tag", 0, {pa_tag, pb_tag});
    tx_frame(MC, 16'h2222);
    chk("pa_seq2", s1 + 16'h0001, pa_seq);
    chk("pb_seq2", s1 + 16'h0001, pb_seq);
  endtask

  task automatic t_par_rx();
    snap();
    rx(0, STA, SX, 16'h000A);
    rx(1, STA, SX, 16'h000A);
    chk("dlv_first", d0 + 1, n_dlv);
    chk("dlv_seq", 16'h000A, dl_seq);
    chk("dlv_port", 0, dl_port);
    chk("dlv_addr", {STA, SX, 16'h5A5A}, {dl_dst, dl_src, dl_tok});
    rx(1, MC, SX, 16'h000B);
    chk("dlv_group", d0 + 2, n_dlv);
    chk("seq_ok_b", 0, n_eb);
    rx(0, OTH, SX, 16'h000C);
    chk("dlv_other", d0 + 2, n_dlv);
    chk("no_relay", {a0, b0}, {n_a, n_b});
    a0 = n_ea;
    rx(0, STA, SY, 16'h000D);
    chk("seq_ok", a0, n_ea);
    rx(0, STA, SY, 16'h0010);
    chk("seq_gap", a0 + 1, n_ea);
  endtask

  task automatic t_ring_tx();
    set_mode(1'b1);
    #1 slow_b = 1'b1;
    tx_frame(MC, 16'h3333);
    s1 = pa_seq;
    chk("r_tag", 2'h3, {pa_tag, pb_tag});
    chk("r_dst", {MC, MC}, {pa_dst, pb_dst});
    chk("r_tok", 16'h3333, pb_tok);
    chk("r_src", STA, pb_src);
    chk("r_seqb", s1 + 16'h0001, pb_seq);
    tx_frame(MC, 16'h4444);
    chk("r_seq2", s1 + 16'h0002, pa_seq);
    #1 slow_b = 1'b0;
  endtask

  task automatic t_ring_rx();
    snap();
    rx(0, OTH, SY, 16'h0014);
    chk("rl_cnt", {b0 + 1, a0, d0}, {n_b, n_a, n_dlv});
    chk("rl_dst", OTH, pb_dst);
    chk("rl_src", SY, pb_src);
    chk("rl_seq", 16'h0014, pb_seq);
    chk("rl_tag", 1, pb_tag);
    rx(0, STA, SZ, 16'h001E);
    rx(1, STA, SZ, 16'h001F);
    chk("dst_cnt", {b0 + 1, a0, d0 + 1}, {n_b, n_a, n_dlv});
    chk("dst_seq", 16'h001E, dl_seq);
    rx(0, MC, STA, 16'h0028);
    chk("own_cnt", {b0 + 1, a0, d0 + 1}, {n_b, n_a, n_dlv});
    rx(1, MC, SY, 16'h0032);
    chk("mc_cnt", {a0 + 1, d0 + 2}, {n_a, n_dlv});
    chk("mc_port", 1, dl_port);
  endtask

  task automatic t_forget();
    int l0;
    l0 = n_lone;
    snap();
    rx(0, STA, SX, 16'h003C);
    repeat (700) @(posedge clk);
    chk("lone", 1, n_lone > l0);
    rx(1, STA, SX, 16'h003D);
    chk("forgot", d0 + 2, n_dlv);
  endtask

  // A frozen clock enable must hold off a waiting host frame and drop every ready.
  task automatic t_ce();
    snap();
    @(posedge clk);
    #1 {ce, hd, ht, hv} = {1'b0, OTH, 16'h6666, 1'b1};
    repeat (4) @(posedge clk);
    chk("ce_rdy", 0, {hr, arr, brr});
    chk("ce_hold", {a0, b0}, {n_a, n_b});
    #1 {ce, hv} = 2'h2;
  endtask

  task automatic t_sup();
    int i;
    for (i = 0; i < 5000 && !(av === 1'b1 && as === 1'b1); i++) @(posedge clk);
    if (i == 5000) tmo();
    chk("sup_dst", SUP_DST_DEF, ad);
    chk("sup_tok", 0, ak);
    chk("sup_b", 2'h3, {bv, bs});
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {rst_b, ring, slow_b, hv, hd, ht} = '0;
    ce = 1'b1;
    {n_dlv, n_ea, n_eb, n_lone, mismatches, num_checks} = '0;
    repeat (2) @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (6) @(posedge clk);
    t_par_tx();
    t_ce();
    t_par_rx();
    t_ring_tx();
    t_ring_rx();
    t_forget();
    t_sup();
    test_done();
  end
endmodule // testbench
`default_nettype wire
